// [verilog/dbsc_defines.vh]
`ifndef DBSC_DEFINES_VH
`define DBSC_DEFINES_VH

// Register indexes; byte address is four times the index
`define DBSC_IDX_DESAT_CTRL     10'h190
`define DBSC_IDX_CUR_OFFSET     10'h191
`define DBSC_IDX_BLANKING       10'h192
`define DBSC_IDX_SLOPE          10'h193
`define DBSC_IDX_DEADTIME       10'h194
`define DBSC_IDX_DRV_OPTION     10'h195
`define DBSC_IDX_OFFSET_TRIM    10'h196
`define DBSC_IDX_DESAT_FLAG     10'h197

// Desaturation control fields
`define DBSC_DS_INPUT_SEL_BIT   7
`define DBSC_DS_WDT_EN_BIT      6
`define DBSC_DS_RESERVED_BIT    5
`define DBSC_DS_POLARITY_BIT    4
`define DBSC_DS_OUT_EN_BIT      3
`define DBSC_DS_STATUS_BIT      2
`define DBSC_DS_RISE_EN_BIT     1
`define DBSC_DS_FALL_EN_BIT     0
`define DBSC_DS_FLAG_BIT        0

// Other fields
`define DBSC_SLOPE_BYPASS_BIT   6
`define DBSC_PRI_DT_BYPASS_BIT  1
`define DBSC_SEC_DT_BYPASS_BIT  0

// Reset values
`define DBSC_RST_DESAT_CTRL     8'h00
`define DBSC_RST_CUR_OFFSET     4'h0
`define DBSC_RST_BLANKING       2'h0
`define DBSC_RST_SLOPE          7'h00
`define DBSC_RST_DEADTIME       8'h00
`define DBSC_RST_DRV_OPTION     2'h0
`define DBSC_RST_OFFSET_TRIM    8'h00

// Timing
`define DBSC_CLK_PERIOD_NS      20
`define DBSC_LEB_SEL1_NS        50
`define DBSC_LEB_SEL2_NS        100
`define DBSC_LEB_SEL3_NS        200
`define DBSC_DEAD_STEP_NS       16
`define DBSC_CUR_OFFSET_STEP_MV 50
`define DBSC_NS_TO_CYC(ns) (((ns) + `DBSC_CLK_PERIOD_NS - 1) / `DBSC_CLK_PERIOD_NS)

`endif

// [verilog/dbsc_turn_on_delay.v]
`timescale 1ns/10ps
`include "dbsc_defines.vh"

module dbsc_turn_on_delay #(
  parameter CODE_W = 4
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              drive_in,
  input  wire              bypass,
  input  wire [CODE_W-1:0] delay_code,
  output wire              drive_out
);

  reg [4:0] cnt_reg;
  reg       out_reg;

  // Least time, rounded up to whole clocks
  function [4:0] delay_cycles;
    input [CODE_W-1:0] code;
    integer            ns;
    integer            cyc;
    begin
      ns           = (code + 1) * `DBSC_DEAD_STEP_NS;
      cyc          = `DBSC_NS_TO_CYC(ns);
      delay_cycles = cyc[4:0];
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 5'h00;
      out_reg <= 1'b0;
    end else if (!drive_in) begin
      cnt_reg <= 5'h00;
      out_reg <= 1'b0;
    end else if (bypass) begin
      out_reg <= 1'b1;
    end else if (!out_reg) begin
      if (cnt_reg + 5'h01 >= delay_cycles(delay_code)) begin
        out_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  assign drive_out = out_reg;

endmodule

// [verilog/dbsc_desat_blanking_slope.v]
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`include "dbsc_defines.vh"

module dbsc_desat_blanking_slope (
  input  wire        SYS_CLK,
  input  wire        RST_N,
  input  wire [11:0] AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output wire [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  input  wire        DESAT_COMPARE_RAW,
  input  wire        DESAT_WATCHDOG,
  input  wire        PRIMARY_CURRENT_TRIP_RAW,
  input  wire        PWM_PRIMARY_IN,
  input  wire        PWM_SECONDARY_IN,
  output wire        DESAT_INPUT_SELECT,
  output wire [7:0]  DESAT_OFFSET_TRIM,
  output wire        DESAT_PWM_ACTION,
  output wire        PWM_WATCHDOG_RESET,
  output wire [3:0]  CURRENT_OFFSET_CODE,
  output wire [9:0]  CURRENT_OFFSET_MV,
  output wire        PRIMARY_CURRENT_TRIP,
  output wire        SLOPE_ENABLE,
  output wire [5:0]  SLOPE_RATE_CODE,
  output wire        PRIMARY_GATE_DRIVE,
  output wire        SECONDARY_GATE_DRIVE
);

  // Constants held at the width of their targets
  localparam [6:0] slope_rst_val  = `DBSC_RST_SLOPE;
  localparam [9:0] offset_step_mv = `DBSC_CUR_OFFSET_STEP_MV;

  // Reset release
  reg  [1:0] rst_sync_reg;
  wire       rst_n_int;

  // Bus handshake
  reg        ack_reg;
  reg [31:0] readdata_reg;
  wire       bus_req;
  wire       wr_go;
  wire [9:0] word_idx;

  // Software registers
  reg [7:0]  desat_ctrl_reg;
  reg        desat_event_flag_reg;
  reg [3:0]  current_offset_code_reg;
  reg [1:0]  blanking_select_reg;
  reg        slope_bypass_reg;
  reg [5:0]  slope_rate_code_reg;
  reg [7:0]  deadtime_config_reg;
  reg [1:0]  driver_option_reg;
  reg [7:0]  desat_offset_trim_reg;

  // Pin synchronisers and filtered levels
  reg [2:0]  desat_sync_reg;
  reg        desat_level_reg;
  reg [2:0]  trip_sync_reg;
  reg        trip_level_reg;

  // Desaturation path
  reg        desat_out_prev_reg;
  reg        desat_action_reg;
  reg        wdt_reset_reg;
  wire       desat_out;
  wire       desat_rise;
  wire       desat_fall;
  wire       desat_set;
  wire       flag_clear;
  reg        desat_event_flag_next;

  // Blanking
  reg [3:0]  blank_cnt_reg;
  reg [3:0]  blank_cnt_next;
  reg        pri_gate_prev_reg;
  reg        trip_out_reg;
  wire       pri_gate;
  wire       sec_gate;
  wire       pri_rise;
  wire       blanking_active;

  // Blanking interval in clocks, least time rounded up
  function [3:0] blank_cycles;
    input [1:0] sel;
    integer     cyc;
    begin
      case (sel)
        2'h1:    cyc = `DBSC_NS_TO_CYC(`DBSC_LEB_SEL1_NS);
        2'h2:    cyc = `DBSC_NS_TO_CYC(`DBSC_LEB_SEL2_NS);
        2'h3:    cyc = `DBSC_NS_TO_CYC(`DBSC_LEB_SEL3_NS);
        default: cyc = 0;
      endcase
      blank_cycles = cyc[3:0];
    end
  endfunction

  // Pin input stage: change accepted once stages two and three agree
  function filt_next;
    input [2:0] sync;
    input       level;
    begin
      if (sync[1] == sync[2]) begin
        filt_next = sync[2];
      end else begin
        filt_next = level;
      end
    end
  endfunction

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync_reg[1];

  // Avalon slave: one wait cycle, then answer
  assign bus_req         = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = bus_req & ~ack_reg;
  assign wr_go           = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
  assign word_idx        = AVS_ADDRESS[11:2];
  assign AVS_READDATA    = readdata_reg;

  always @(posedge SYS_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  always @(posedge SYS_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      readdata_reg <= 32'h00000000;
    end else if (AVS_READ & ~ack_reg) begin
      case (word_idx)
        `DBSC_IDX_DESAT_CTRL: begin
          readdata_reg <= {24'h000000, desat_ctrl_reg[7:3], desat_out,
                           desat_ctrl_reg[1:0]};
        end
        `DBSC_IDX_CUR_OFFSET: begin
          readdata_reg <= {28'h0000000, current_offset_code_reg};
        end
        `DBSC_IDX_BLANKING: begin
          readdata_reg <= {30'h00000000, blanking_select_reg};
        end
        `DBSC_IDX_SLOPE: begin
          readdata_reg <= {25'h0000000, slope_bypass_reg, slope_rate_code_reg};
        end
        `DBSC_IDX_DEADTIME: begin
          readdata_reg <= {24'h000000, deadtime_config_reg};
        end
        `DBSC_IDX_DRV_OPTION: begin
          readdata_reg <= {30'h00000000, driver_option_reg};
        end
        `DBSC_IDX_OFFSET_TRIM: begin
          readdata_reg <= {24'h000000, desat_offset_trim_reg};
        end
        `DBSC_IDX_DESAT_FLAG: begin
          readdata_reg <= {31'h00000000, desat_event_flag_reg};
        end
        default: begin
          readdata_reg <= 32'h00000000;
        end
      endcase
    end
  end

  // Register writes; the status bit is read-only
  always @(posedge SYS_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      desat_ctrl_reg          <= `DBSC_RST_DESAT_CTRL;
      current_offset_code_reg <= `DBSC_RST_CUR_OFFSET;
      blanking_select_reg     <= `DBSC_RST_BLANKING;
      slope_bypass_reg        <= slope_rst_val[`DBSC_SLOPE_BYPASS_BIT];
      slope_rate_code_reg     <= slope_rst_val[5:0];
      deadtime_config_reg     <= `DBSC_RST_DEADTIME;
      driver_option_reg       <= `DBSC_RST_DRV_OPTION;
      desat_offset_trim_reg   <= `DBSC_RST_OFFSET_TRIM;
    end else if (wr_go) begin
      case (word_idx)
        `DBSC_IDX_DESAT_CTRL: begin
          desat_ctrl_reg <= {AVS_WRITEDATA[7:3], 1'b0, AVS_WRITEDATA[1:0]};
        end
        `DBSC_IDX_CUR_OFFSET: begin
          current_offset_code_reg <= AVS_WRITEDATA[3:0];
        end
        `DBSC_IDX_BLANKING: begin
          blanking_select_reg <= AVS_WRITEDATA[1:0];
        end
        `DBSC_IDX_SLOPE: begin
          slope_bypass_reg    <= AVS_WRITEDATA[`DBSC_SLOPE_BYPASS_BIT];
          slope_rate_code_reg <= AVS_WRITEDATA[5:0];
        end
        `DBSC_IDX_DEADTIME: begin
          deadtime_config_reg <= AVS_WRITEDATA[7:0];
        end
        `DBSC_IDX_DRV_OPTION: begin
          driver_option_reg <= AVS_WRITEDATA[1:0];
        end
        `DBSC_IDX_OFFSET_TRIM: begin
          desat_offset_trim_reg <= AVS_WRITEDATA[7:0];
        end
        default: begin
          desat_offset_trim_reg <= desat_offset_trim_reg;
        end
      endcase
    end
  end

  // Pin synchronisers
  always @(posedge SYS_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      desat_sync_reg  <= 3'h0;
      desat_level_reg <= 1'b0;
      trip_sync_reg   <= 3'h0;
      trip_level_reg  <= 1'b0;
    end else begin
      desat_sync_reg  <= {desat_sync_reg[1:0], DESAT_COMPARE_RAW};
      desat_level_reg <= filt_next(desat_sync_reg, desat_level_reg);
      trip_sync_reg   <= {trip_sync_reg[1:0], PRIMARY_CURRENT_TRIP_RAW};
      trip_level_reg  <= filt_next(trip_sync_reg, trip_level_reg);
    end
  end

  // Desaturation comparator output, edges and flag
  assign desat_out  = desat_level_reg ^ desat_ctrl_reg[`DBSC_DS_POLARITY_BIT];
  assign desat_rise = desat_out & ~desat_out_prev_reg;
  assign desat_fall = ~desat_out & desat_out_prev_reg;
  assign desat_set  = (desat_rise & desat_ctrl_reg[`DBSC_DS_RISE_EN_BIT])
                    | (desat_fall & desat_ctrl_reg[`DBSC_DS_FALL_EN_BIT]);
  assign flag_clear = wr_go & (word_idx == `DBSC_IDX_DESAT_FLAG)
                    & AVS_WRITEDATA[`DBSC_DS_FLAG_BIT];

  always @* begin
    desat_event_flag_next = desat_event_flag_reg;
    if (flag_clear) begin
      desat_event_flag_next = 1'b0;
    end
    if (desat_set) begin
      desat_event_flag_next = 1'b1;
    end
  end

  always @(posedge SYS_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      desat_out_prev_reg   <= 1'b0;
      desat_event_flag_reg <= 1'b0;
      desat_action_reg     <= 1'b0;
      wdt_reset_reg        <= 1'b0;
    end else begin
      desat_out_prev_reg   <= desat_out;
      desat_event_flag_reg <= desat_event_flag_next;
      desat_action_reg     <= desat_out & desat_ctrl_reg[`DBSC_DS_OUT_EN_BIT];
      wdt_reset_reg        <= DESAT_WATCHDOG & desat_ctrl_reg[`DBSC_DS_WDT_EN_BIT];
    end
  end

  // Turn-on dead timers
  dbsc_turn_on_delay #(
    .CODE_W (4)
  ) u_primary_delay (
    .clk        (SYS_CLK),
    .rst_n      (rst_n_int),
    .drive_in   (PWM_PRIMARY_IN),
    .bypass     (driver_option_reg[`DBSC_PRI_DT_BYPASS_BIT]),
    .delay_code (deadtime_config_reg[7:4]),
    .drive_out  (pri_gate)
  );

  dbsc_turn_on_delay #(
    .CODE_W (4)
  ) u_secondary_delay (
    .clk        (SYS_CLK),
    .rst_n      (rst_n_int),
    .drive_in   (PWM_SECONDARY_IN),
    .bypass     (driver_option_reg[`DBSC_SEC_DT_BYPASS_BIT]),
    .delay_code (deadtime_config_reg[3:0]),
    .drive_out  (sec_gate)
  );

  // Leading-edge blanking after primary turn-on
  assign pri_rise        = pri_gate & ~pri_gate_prev_reg;
  assign blanking_active = (pri_rise & (blanking_select_reg != 2'h0))
                         | (blank_cnt_reg != 4'h0);

  always @* begin
    blank_cnt_next = blank_cnt_reg;
    if (pri_rise) begin
      if (blanking_select_reg != 2'h0) begin
        blank_cnt_next = blank_cycles(blanking_select_reg) - 4'h1;
      end else begin
        blank_cnt_next = 4'h0;
      end
    end else if (blank_cnt_reg != 4'h0) begin
      blank_cnt_next = blank_cnt_reg - 4'h1;
    end
  end

  always @(posedge SYS_CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pri_gate_prev_reg <= 1'b0;
      blank_cnt_reg     <= 4'h0;
      trip_out_reg      <= 1'b0;
    end else begin
      pri_gate_prev_reg <= pri_gate;
      blank_cnt_reg     <= blank_cnt_next;
      trip_out_reg      <= trip_level_reg & pri_gate & ~blanking_active;
    end
  end

  // Outputs to the analog side
  assign DESAT_INPUT_SELECT   = desat_ctrl_reg[`DBSC_DS_INPUT_SEL_BIT];
  assign DESAT_OFFSET_TRIM    = desat_offset_trim_reg;
  assign DESAT_PWM_ACTION     = desat_action_reg;
  assign PWM_WATCHDOG_RESET   = wdt_reset_reg;
  assign CURRENT_OFFSET_CODE  = current_offset_code_reg;
  assign CURRENT_OFFSET_MV    = {6'h00, current_offset_code_reg} * offset_step_mv;
  assign PRIMARY_CURRENT_TRIP = trip_out_reg;
  assign SLOPE_ENABLE         = ~slope_bypass_reg;
  assign SLOPE_RATE_CODE      = slope_rate_code_reg;
  assign PRIMARY_GATE_DRIVE   = pri_gate;
  assign SECONDARY_GATE_DRIVE = sec_gate;

endmodule

// [verification/dbsc_sva.sv]
`timescale 1ns/10ps
module dbsc_sva (
  input wire        SYS_CLK,
  input wire        RST_N,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire        AVS_WAITREQUEST,
  input wire [31:0] AVS_READDATA,
  input wire        DESAT_WATCHDOG,
  input wire        PWM_WATCHDOG_RESET,
  input wire [3:0]  CURRENT_OFFSET_CODE,
  input wire [9:0]  CURRENT_OFFSET_MV,
  input wire        PRIMARY_CURRENT_TRIP,
  input wire        PRIMARY_GATE_DRIVE,
  input wire        SECONDARY_GATE_DRIVE,
  input wire        PWM_PRIMARY_IN,
  input wire        PWM_SECONDARY_IN
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire rq = AVS_READ | AVS_WRITE;

  property p_first; $rose(rq) |-> AVS_WAITREQUEST; endproperty
  a_first: assert property (p_first) else $error("no wait cycle");
  property p_wait; rq && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_wait: assert property (p_wait) else $error("second wait cycle");
  property p_hi; AVS_READDATA[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_wdt; !DESAT_WATCHDOG |=> !PWM_WATCHDOG_RESET; endproperty
  a_wdt: assert property (p_wdt) else $error("reset without cause");
  property p_mv; CURRENT_OFFSET_MV == CURRENT_OFFSET_CODE * 10'd50; endproperty
  a_mv: assert property (p_mv) else $error("offset mv wrong");
  property p_trip;
    PRIMARY_CURRENT_TRIP |-> PRIMARY_GATE_DRIVE || $past(PRIMARY_GATE_DRIVE);
  endproperty
  a_trip: assert property (p_trip) else $error("trip while off");
  property p_poff; !PWM_PRIMARY_IN |=> !PRIMARY_GATE_DRIVE; endproperty
  a_poff: assert property (p_poff) else $error("primary stays on");
  property p_soff; !PWM_SECONDARY_IN |=> !SECONDARY_GATE_DRIVE; endproperty
  a_soff: assert property (p_soff) else $error("secondary stays on");

  c_rd: cover property (AVS_READ && !AVS_WAITREQUEST);
  c_trip: cover property ($rose(PRIMARY_CURRENT_TRIP));
  c_wdt: cover property (PWM_WATCHDOG_RESET);
endmodule

bind dbsc_desat_blanking_slope dbsc_sva u_sva (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA),
  .DESAT_WATCHDOG(DESAT_WATCHDOG), .PWM_WATCHDOG_RESET(PWM_WATCHDOG_RESET),
  .CURRENT_OFFSET_CODE(CURRENT_OFFSET_CODE), .CURRENT_OFFSET_MV(CURRENT_OFFSET_MV),
  .PRIMARY_CURRENT_TRIP(PRIMARY_CURRENT_TRIP), .PRIMARY_GATE_DRIVE(PRIMARY_GATE_DRIVE),
  .SECONDARY_GATE_DRIVE(SECONDARY_GATE_DRIVE), .PWM_PRIMARY_IN(PWM_PRIMARY_IN),
  .PWM_SECONDARY_IN(PWM_SECONDARY_IN));

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [11:0] adr = 0;
  logic        rd = 0, wr = 0, wdg = 0, raw = 0, trw = 0, pin = 0, sin = 0;
  logic [31:0] wd = 0;
  logic [3:0]  be = 4'hf;
  logic [7:0]  q, d, c;
  wire  [31:0] rdat;
  wire  [7:0]  trim;
  wire  [9:0]  cmv;
  wire  [5:0]  src;
  wire  [3:0]  coc;
  wire         wt, isel, pact, wrst, trip, sen, primary_gate_drive, secondary_gate_drive;
  int          n_errors = 0, total_checks = 0, n, np, ns, m;
  logic [7:0]  msk [7] = '{8'hfb, 8'h0f, 8'h03, 8'h7f, 8'hff, 8'h03, 8'hff};

  initial forever #10 clk = ~clk;

  dbsc_desat_blanking_slope dut (
    .SYS_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt),
    .DESAT_COMPARE_RAW(raw), .DESAT_WATCHDOG(wdg), .PRIMARY_CURRENT_TRIP_RAW(trw),
    .PWM_PRIMARY_IN(pin), .PWM_SECONDARY_IN(sin), .DESAT_INPUT_SELECT(isel),
    .DESAT_OFFSET_TRIM(trim), .DESAT_PWM_ACTION(pact), .PWM_WATCHDOG_RESET(wrst),
    .CURRENT_OFFSET_CODE(coc), .CURRENT_OFFSET_MV(cmv), .PRIMARY_CURRENT_TRIP(trip),
    .SLOPE_ENABLE(sen), .SLOPE_RATE_CODE(src), .PRIMARY_GATE_DRIVE(primary_gate_drive),
    .SECONDARY_GATE_DRIVE(secondary_gate_drive));

  // Turn-on delay in clocks, rounded up
  function automatic int dt(input logic [3:0] k);
    return (16 * (k + 1) + 19) / 20;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic acc(input logic w, input logic [9:0] i, input logic [7:0] v);
    @(posedge clk);
    adr <= {i, 2'b00};
    wr <= w;
    rd <= !w;
    wd <= {24'h0, v};
    // Waitrequest is judged where it has settled, ahead of the edge it qualifies
    @(negedge clk);
    while (wt !== 1'b0) @(negedge clk);
    @(posedge clk);
    q = rdat[7:0];
    rd <= 0;
    wr <= 0;
    @(negedge clk);
  endtask

  task automatic wc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    wc(30000);
    n_errors++;
    $display("[ERR] %0t timeout", $time);
    end_of_test;
  end

  initial begin
    void'($urandom(32'h03e0));
    wc(20);
    rst_n <= 1;
    wc(3);
    for (int i = 0; i < 8; i++) begin
      acc(0, 10'(10'h190 + i), 0);
      chk(q, 0);
    end
    chk(sen, 1);
    acc(0, 10'h1a0, 0);
    chk(q, 0);
    $display("test reset done");
    repeat (24) begin
      n = $urandom % 7;
      d = $urandom;
      acc(1, 10'(10'h190 + n), d);
      acc(0, 10'(10'h190 + n), 0);
      chk(n ? q : q & 8'hfb, d & msk[n]);
    end
    acc(1, 10'h191, 8'hff);
    chk(coc, 4'hf);
    chk(cmv, 10'd750);
    acc(1, 10'h193, 8'h7f);
    chk({sen, src}, 7'h3f);
    acc(1, 10'h193, 8'h2a);
    chk({sen, src}, 7'h6a);
    $display("test registers done");
    for (int k = 0; k < 16; k++) begin
      c = {1'($urandom), 2'b00, k[0], k[1], 3'b000};
      acc(1, 10'h190, c);
      wc(6);
      acc(1, 10'h197, 8'h01);
      acc(1, 10'h190, c | {6'h0, k[2], k[3]});
      @(posedge clk);
      raw <= ~raw;
      wc(8);
      d = {7'h0, (raw ^ k[0]) ? k[2] : k[3]};
      acc(0, 10'h197, 0);
      chk(q, d);
      chk(pact, (raw ^ k[0]) & k[1]);
      chk(isel, c[7]);
      acc(0, 10'h190, 0);
      chk(q[2], raw ^ k[0]);
      acc(0, 10'h197, 0);
      chk(q, d);
    end
    $display("test desat done");
    for (int w = 0; w < 2; w++) begin
      acc(1, 10'h190, {1'b0, w[0], 6'h0});
      @(posedge clk);
      wdg <= 1;
      wc(3);
      chk(wrst, w[0]);
      wdg <= 0;
      wc(2);
    end
    $display("test watchdog done");
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 8'h0f : (k == 1) ? 8'hf0 : 8'($urandom);
      c = (k == 2) ? 8'h02 : (k == 3) ? 8'h01 : 8'h00;
      acc(1, 10'h194, d);
      acc(1, 10'h195, c);
      @(posedge clk);
      pin <= 1;
      sin <= 1;
      n = -1;
      np = 0;
      ns = 0;
      while (n < 20) begin
        @(negedge clk);
        n++;
        if (primary_gate_drive === 1'b1 && np == 0) np = n;
        if (secondary_gate_drive === 1'b1 && ns == 0) ns = n;
      end
      chk(np, c[1] ? 1 : dt(d[7:4]));
      chk(ns, c[0] ? 1 : dt(d[3:0]));
      @(posedge clk);
      pin <= 0;
      sin <= 0;
      wc(2);
    end
    $display("test dead time done");
    acc(1, 10'h195, 8'h02);
    @(posedge clk);
    trw <= 1;
    for (int s = 0; s < 4; s++) begin
      acc(1, 10'h192, 8'(s));
      m = ((s == 3 ? 200 : 50 * s) + 19) / 20;
      @(posedge clk);
      pin <= 1;
      n = -1;
      while (trip !== 1'b1 && n < 30) begin
        @(negedge clk);
        n++;
      end
      chk(n >= m + 1 && n <= m + 3, 1);
      @(posedge clk);
      pin <= 0;
      wc(3);
      chk(trip, 0);
    end
    $display("test blanking done");
    d = $urandom;
    acc(1, 10'h196, d);
    @(posedge clk);
    be <= 4'h0;
    acc(1, 10'h196, ~d);
    @(posedge clk);
    be <= 4'hf;
    acc(0, 10'h196, 0);
    chk(q, d);
    chk(trim, d);
    $display("test trim done");
    end_of_test;
  end
endmodule
